// >>> logic/cpu_mode_mmu_map.svh
// Purpose: offsets, sizes and counts of the mode and memory partition block
// Assumes: byte addresses inside each memory start at zero
// Notes: sizes in bytes
`ifndef CPU_MODE_MMU_MAP_SVH
`define CPU_MODE_MMU_MAP_SVH
`define ROM_APP_SIZE     18'h28000
`define ROM_TEST_SIZE    18'h06000
`define EE_MFR_SIZE      17'h00040
`define EE_CLS_1K        17'h00400
`define EE_CLS_4K        17'h01000
`define RAM_TOTAL        13'h1200
`define RAM_RSV_SIZE     13'h0080
`define RAM_GP_SIZE      13'h0d00
`define CFG_VEC_COUNT    8
`define SYS_VEC_COUNT    32
`define ROM_VEC_BASE     18'h00000
`define CFG_VEC_BASE     18'h28000
`define SYS_VEC_BASE     18'h00100
`define VEC_STRIDE       18'h00008
`define SFR_COUNT        8
`endif

// >>> logic/cpu_mode_pkg.sv
// Purpose: types of the mode and memory partition block
// Assumes: nothing
// Notes: mode order has no meaning
package cpu_mode_pkg;
  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_TEST,
    MODE_CLS,
    MODE_SYSTEM,
    MODE_USER
  } cpu_mode_e;
  typedef enum logic [1:0] {
    MEM_ROM,
    MEM_EE,
    MEM_RAM,
    MEM_SFR
  } mem_space_e;
endpackage

// >>> logic/cpu_mode_memory_partition.sv
// Purpose: CPU privilege mode control and memory partition checking
// Assumes: one CPU access request per cycle, judged in the same cycle
// Notes: the coprocessor port is never blocked by rights, only by partition
//
// Operation
// - Exactly five modes: boot, test, contactless support, system, user.
// - Super-system level is always boot, test or contactless submode.
// - System mode reaches all hardware; user mode only permitted SFRs.
// - System mode software grants user mode access to components.
// - Exceptions and interrupts jump to a ROM vector and enter set mode; here boot and test modes ignore exc_req.
// - 8 configuration calls enter contactless mode; 32 system calls enter system.
// - ROM splits into 160 kByte application and 24 kByte test region.
// - EEPROM keeps 64 bytes for maker plus 0, 1 or 4 kBytes.
// - RAM splits 0/4608 or 128/4480 bytes by configuration.
// - Test mode has no memory restriction.
// - Boot and contactless modes reach only test ROM and small parts.
// - System and user modes reach only application ROM and large parts.
// - Extra user limits are set only from system mode.
// - RAM has 3328 general bytes and 1280 coprocessor bytes.
// - Coprocessor bypasses rights checks but stays inside its partition.
// - A hardware fuse permanently disables test mode; here the fuse flop clears on arst_n.
// - Every reset starts in boot mode with no external interaction.
// - Contactless mode runs only when application software calls it.
// - With test mode enabled, start-up ends in test mode.
// - With test mode disabled, start-up ends in system mode.
`timescale 1ns/1ns
`include "cpu_mode_mmu_map.svh"
module cpu_mode_memory_partition
  import cpu_mode_pkg::*;
#(
  parameter int SFR_N = `SFR_COUNT
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [1:0]       cls_ee_cfg,
  input  wire logic             ram_rsv_cfg,
  input  wire logic             test_fuse_blow,
  input  wire logic             boot_done,
  input  wire logic             exc_req,
  input  wire logic [4:0]       exc_index,
  input  wire logic             exc_to_user,
  input  wire logic             cfg_call,
  input  wire logic [2:0]       cfg_call_index,
  input  wire logic             sys_call,
  input  wire logic [4:0]       sys_call_index,
  input  wire logic             mode_return,
  input  wire logic             return_to_user,
  input  wire logic             grant_we,
  input  wire logic [SFR_N-1:0] grant_data,
  input  wire logic             cpu_req,
  input  wire mem_space_e       cpu_space,
  input  wire logic [17:0]      cpu_addr,
  input  wire logic [$clog2(SFR_N)-1:0] cpu_sfr,
  input  wire logic             cop_req,
  input  wire logic             cop_is_ee,
  input  wire logic [16:0]      cop_addr,
  output cpu_mode_e             mode,
  output logic                  super_level,
  output logic                  test_disabled,
  output logic                  ext_io_enable,
  output logic                  vec_jump,
  output logic [17:0]           vec_addr,
  output logic                  cpu_grant,
  output logic                  access_fault,
  output logic                  cop_grant,
  output logic [SFR_N-1:0]      user_grants
);
  logic        fuse;
  logic [16:0] ee_small;
  logic [12:0] ram_small;
  logic        small_ok;
  logic        large_ok;
  logic        sfr_ok;
  logic        allowed;
  logic        cop_in_ee;
  logic        cop_in_ram;
  cpu_mode_e   next_mode;

  always_comb begin
    case (cls_ee_cfg)
      2'd1:    ee_small = `EE_MFR_SIZE + `EE_CLS_1K;
      2'd2:    ee_small = `EE_MFR_SIZE + `EE_CLS_4K;
      default: ee_small = `EE_MFR_SIZE;
    endcase
  end

  // Reserved RAM is 0 or 128 bytes
  assign ram_small = ram_rsv_cfg ? `RAM_RSV_SIZE : 13'h0000;

  // ROM test region sits above the application region
  always_comb begin
    case (cpu_space)
      MEM_ROM: small_ok = (cpu_addr >= `ROM_APP_SIZE)
                          && (cpu_addr < `ROM_APP_SIZE + `ROM_TEST_SIZE);
      MEM_EE:  small_ok = cpu_addr[16:0] < ee_small && cpu_addr[17] == 1'b0;
      MEM_RAM: small_ok = cpu_addr[12:0] < ram_small && cpu_addr[17:13] == 5'h00;
      default: small_ok = 1'b0;
    endcase
  end

  always_comb begin
    case (cpu_space)
      MEM_ROM: large_ok = cpu_addr < `ROM_APP_SIZE;
      MEM_EE:  large_ok = cpu_addr[16:0] >= ee_small && cpu_addr[17] == 1'b0;
      MEM_RAM: large_ok = cpu_addr[12:0] >= ram_small && cpu_addr[12:0] < `RAM_TOTAL
                          && cpu_addr[17:13] == 5'h00;
      default: large_ok = 1'b0;
    endcase
  end

  // User mode reaches only granted SFRs
  assign sfr_ok = (mode == MODE_SYSTEM) || (mode == MODE_USER && user_grants[cpu_sfr]);

  always_comb begin
    case (mode)
      MODE_TEST:   allowed = (cpu_space == MEM_SFR) || (cpu_space == MEM_ROM
                             && cpu_addr < `ROM_APP_SIZE + `ROM_TEST_SIZE)
                             || (cpu_space == MEM_EE && cpu_addr[17] == 1'b0)
                             || (cpu_space == MEM_RAM && cpu_addr < 18'(`RAM_TOTAL));
      MODE_BOOT,
      MODE_CLS:    allowed = small_ok;
      MODE_SYSTEM,
      MODE_USER:   allowed = (cpu_space == MEM_SFR) ? sfr_ok : large_ok;
      default:     allowed = 1'b0;
    endcase
  end

  // Block forbidden access and flag it
  assign cpu_grant    = cpu_req && allowed;
  assign access_fault = cpu_req && !allowed;

  // Coprocessor RAM is the top 1280 bytes
  assign cop_in_ram = cop_addr >= 17'(`RAM_GP_SIZE) && cop_addr < 17'(`RAM_TOTAL);
  assign cop_in_ee  = cop_addr >= ee_small;
  // No rights check, partition still enforced
  assign cop_grant  = cop_req && (cop_is_ee ? cop_in_ee : cop_in_ram);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse <= 1'b0;
    end else if (test_fuse_blow) begin
      fuse <= 1'b1;
    end
  end
  // Real silicon holds this in a fuse; a reset here would re-enable test
  assign test_disabled = fuse;

  always_comb begin
    next_mode = mode;
    case (mode)
      // Boot leaves only when setup completes
      MODE_BOOT: begin
        if (boot_done) begin
          next_mode = fuse ? MODE_SYSTEM : MODE_TEST;
        end
      end
      MODE_TEST: next_mode = MODE_TEST;
      MODE_CLS: begin
        if (exc_req) begin
          next_mode = exc_to_user ? MODE_USER : MODE_SYSTEM;
        end else if (mode_return) begin
          next_mode = return_to_user ? MODE_USER : MODE_SYSTEM;
        end
      end
      MODE_SYSTEM,
      MODE_USER: begin
        if (exc_req || access_fault) begin
          next_mode = (exc_req && exc_to_user) ? MODE_USER : MODE_SYSTEM;
        end else if (cfg_call) begin
          next_mode = MODE_CLS;
        end else if (sys_call) begin
          next_mode = MODE_SYSTEM;
        end else if (mode_return && mode == MODE_SYSTEM && return_to_user) begin
          next_mode = MODE_USER;
        end
      end
      default: next_mode = MODE_BOOT;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= MODE_BOOT;
    end else begin
      mode <= next_mode;
    end
  end

  // Super level is exactly one of three submodes
  assign super_level   = (mode == MODE_BOOT) || (mode == MODE_TEST) || (mode == MODE_CLS);
  assign ext_io_enable = (mode != MODE_BOOT);

  // Vector address registered with the mode change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vec_jump <= 1'b0;
      vec_addr <= 18'h00000;
    end else begin
      vec_jump <= 1'b0;
      if ((mode == MODE_SYSTEM || mode == MODE_USER || mode == MODE_CLS)
          && (exc_req || access_fault && mode != MODE_CLS)) begin
        vec_jump <= 1'b1;
        vec_addr <= `ROM_VEC_BASE + 18'(exc_req ? exc_index : 5'h1f) * `VEC_STRIDE;
      end else if (mode == MODE_SYSTEM || mode == MODE_USER) begin
        if (cfg_call) begin
          vec_jump <= 1'b1;
          vec_addr <= `CFG_VEC_BASE + 18'(cfg_call_index) * `VEC_STRIDE;
        end else if (sys_call) begin
          vec_jump <= 1'b1;
          vec_addr <= `SYS_VEC_BASE + 18'(sys_call_index) * `VEC_STRIDE;
        end
      end
    end
  end

  // Grants written only from system mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      user_grants <= '0;
    end else if (grant_we && mode == MODE_SYSTEM) begin
      user_grants <= grant_data;
    end
  end

  boot_first_a: assert property (@(posedge clk) $rose(arst_n) |-> mode == MODE_BOOT)
    else $error("mode after reset is not boot");
  boot_io_a: assert property (@(posedge clk) disable iff (!arst_n)
    mode == MODE_BOOT |-> !ext_io_enable)
    else $error("external interaction enabled during boot");
  boot_to_test_a: assert property (@(posedge clk) disable iff (!arst_n)
    mode == MODE_BOOT && boot_done && !fuse |=> mode == MODE_TEST)
    else $error("boot did not lead to test");
  boot_to_sys_a: assert property (@(posedge clk) disable iff (!arst_n)
    mode == MODE_BOOT && boot_done && fuse |=> mode == MODE_SYSTEM)
    else $error("boot did not lead to system");
  test_stay_a: assert property (@(posedge clk) disable iff (!arst_n)
    mode == MODE_TEST |=> mode == MODE_TEST)
    else $error("test mode was left without reset");
  // Calls count only when nothing of higher priority is taken on the same edge
  sequence s_cfg_call;
    mode == MODE_SYSTEM && cfg_call && !exc_req && !access_fault;
  endsequence
  sequence s_sys_call;
    (mode == MODE_SYSTEM || mode == MODE_USER) && sys_call && !cfg_call
      && !exc_req && !access_fault;
  endsequence
  sequence s_exc_taken;
    exc_req && (mode == MODE_SYSTEM || mode == MODE_USER || mode == MODE_CLS);
  endsequence
  cfg_call_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_cfg_call |=> mode == MODE_CLS && vec_jump)
    else $error("configuration call did not enter contactless mode");
  sys_call_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_sys_call |=> mode == MODE_SYSTEM && vec_jump
      && vec_addr == 18'h00100 + {10'h000, $past(sys_call_index), 3'h0})
    else $error("system call did not reach its vector");
  cls_enter_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(mode == MODE_CLS) |-> $past(cfg_call))
    else $error("contactless mode entered without a call");
  exc_vector_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_exc_taken |=> vec_jump && vec_addr == {10'h000, $past(exc_index), 3'h0})
    else $error("exception vector address wrong");
  exc_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
    s_exc_taken |=> mode == ($past(exc_to_user) ? MODE_USER : MODE_SYSTEM))
    else $error("exception entered the wrong mode");
  fault_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    access_fault |-> !cpu_grant && cpu_req)
    else $error("blocked access was granted");
  fault_vector_a: assert property (@(posedge clk) disable iff (!arst_n)
    access_fault && !exc_req && (mode == MODE_SYSTEM || mode == MODE_USER)
      |=> mode == MODE_SYSTEM && vec_jump && vec_addr == 18'h000f8)
    else $error("access fault did not vector to system mode");
  small_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_grant && (mode == MODE_BOOT || mode == MODE_CLS)
      |-> cpu_space != MEM_SFR && !(cpu_space == MEM_ROM && cpu_addr < `ROM_APP_SIZE))
    else $error("super level submode left its small parts");
  app_rom_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_grant && mode == MODE_USER && cpu_space == MEM_ROM |-> cpu_addr < `ROM_APP_SIZE)
    else $error("user reached test ROM");
  user_sfr_a: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_grant && mode == MODE_USER && cpu_space == MEM_SFR |-> user_grants[cpu_sfr])
    else $error("user reached an SFR without a grant");
  fuse_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    fuse |=> fuse)
    else $error("test disable fuse cleared");
  grant_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
    mode != MODE_SYSTEM |=> user_grants == $past(user_grants))
    else $error("grants changed outside system mode");
  cop_part_a: assert property (@(posedge clk) disable iff (!arst_n)
    cop_grant && !cop_is_ee |-> cop_addr >= 17'(`RAM_GP_SIZE))
    else $error("coprocessor left its RAM");
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench of the mode and memory partition block
// Assumes: inputs change at the falling edge, access and coprocessor grants are judged 2 ns later, other outputs at that edge
// Notes: fuse and test mode clear only through arst_n, so each start-up path resets
`timescale 1ns/1ns
`include "cpu_mode_mmu_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import cpu_mode_pkg::*;
  int          failures = 0;
  int          n_checks = 0;
  logic        clk = 0, arst_n = 0, ram_rsv_cfg = 1, test_fuse_blow = 0, boot_done = 0;
  logic        exc_req = 0, exc_to_user = 0, cfg_call = 0, sys_call = 0, mode_return = 0;
  logic        return_to_user = 0, grant_we = 0, cpu_req = 0, cop_req = 0, cop_is_ee = 0;
  logic [1:0]  cls_ee_cfg = 2'h1;
  logic [4:0]  exc_index = 5'h00, sys_call_index = 5'h00;
  logic [2:0]  cfg_call_index = 3'h0, cpu_sfr = 3'h0;
  logic [7:0]  grant_data = 8'h00, user_grants;
  logic [17:0] cpu_addr = 18'h00000, vec_addr;
  logic [16:0] cop_addr = 17'h00000;
  mem_space_e  cpu_space = MEM_ROM;
  cpu_mode_e   mode;
  logic        super_level, test_disabled, ext_io_enable, vec_jump, cpu_grant;
  logic        access_fault, cop_grant;
  cpu_mode_memory_partition i_cpu_mode_memory_partition (.clk(clk), .arst_n(arst_n),
    .cls_ee_cfg(cls_ee_cfg), .ram_rsv_cfg(ram_rsv_cfg), .test_fuse_blow(test_fuse_blow),
    .boot_done(boot_done), .exc_req(exc_req), .exc_index(exc_index),
    .exc_to_user(exc_to_user), .cfg_call(cfg_call), .cfg_call_index(cfg_call_index),
    .sys_call(sys_call), .sys_call_index(sys_call_index), .mode_return(mode_return),
    .return_to_user(return_to_user), .grant_we(grant_we), .grant_data(grant_data),
    .cpu_req(cpu_req), .cpu_space(cpu_space), .cpu_addr(cpu_addr), .cpu_sfr(cpu_sfr),
    .cop_req(cop_req), .cop_is_ee(cop_is_ee), .cop_addr(cop_addr), .mode(mode),
    .super_level(super_level), .test_disabled(test_disabled),
    .ext_io_enable(ext_io_enable), .vec_jump(vec_jump), .vec_addr(vec_addr),
    .cpu_grant(cpu_grant), .access_fault(access_fault), .cop_grant(cop_grant),
    .user_grants(user_grants));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic go();
    @(negedge clk);
  endtask
  task automatic do_reset();
    arst_n = 0;
    repeat (10) go();
    arst_n = 1;
    go();
  endtask
  // Refused requests raise the fault flag in the same cycle
  task automatic acc(input mem_space_e sp, input logic [17:0] a, input logic [2:0] s,
                     input logic g);
    cpu_req = 1;
    cpu_space = sp;
    cpu_addr = a;
    cpu_sfr = s;
    #2;
    `CHK(cpu_grant, g)
    `CHK(access_fault, ~g)
    go();
    cpu_req = 0;
  endtask
  task automatic cop(input logic ee, input logic [16:0] a, input logic g);
    cop_req = 1;
    cop_is_ee = ee;
    cop_addr = a;
    #2;
    `CHK(cop_grant, g)
    go();
    cop_req = 0;
  endtask
  task automatic chkv(input cpu_mode_e m, input logic [17:0] a);
    `CHK(mode, m)
    `CHK(vec_jump, 1'b1)
    `CHK(vec_addr, a)
  endtask
  task automatic t_test_path();
    do_reset();
    `CHK(mode, MODE_BOOT)
    `CHK(super_level, 1'b1)
    `CHK(ext_io_enable, 1'b0)
    acc(MEM_ROM, 18'h28000, 3'h0, 1'b1);
    boot_done = 1;
    go();
    boot_done = 0;
    `CHK(mode, MODE_TEST)
    `CHK(ext_io_enable, 1'b1)
    acc(MEM_ROM, 18'h00000, 3'h0, 1'b1);
    acc(MEM_RAM, 18'h011ff, 3'h0, 1'b1);
    acc(MEM_EE, 18'h00000, 3'h0, 1'b1);
    cfg_call = 1;
    go();
    cfg_call = 0;
    `CHK(mode, MODE_TEST)
    `CHK(vec_jump, 1'b0)
    do_reset();
    acc(MEM_ROM, 18'h00000, 3'h0, 1'b0);
  endtask
  // Fuse blown in boot, then start-up must land in system mode
  task automatic t_startup();
    do_reset();
    `CHK(test_disabled, 1'b0)
    test_fuse_blow = 1;
    go();
    test_fuse_blow = 0;
    `CHK(test_disabled, 1'b1)
    boot_done = 1;
    go();
    boot_done = 0;
    `CHK(mode, MODE_SYSTEM)
    `CHK(super_level, 1'b0)
    acc(MEM_ROM, 18'h27fff, 3'h0, 1'b1);
    acc(MEM_ROM, 18'h28000, 3'h0, 1'b0);
    chkv(MODE_SYSTEM, 18'h000f8);
    acc(MEM_EE, 18'h0043f, 3'h0, 1'b0);
    acc(MEM_EE, 18'h00440, 3'h0, 1'b1);
    acc(MEM_RAM, 18'h0007f, 3'h0, 1'b0);
    acc(MEM_RAM, 18'h00080, 3'h0, 1'b1);
  endtask
  task automatic t_calls();
    cfg_call = 1;
    cfg_call_index = 3'h2;
    go();
    cfg_call = 0;
    chkv(MODE_CLS, 18'h28010);
    acc(MEM_RAM, 18'h0007f, 3'h0, 1'b1);
    acc(MEM_EE, 18'h0043f, 3'h0, 1'b1);
    mode_return = 1;
    go();
    mode_return = 0;
    `CHK(mode, MODE_SYSTEM)
    sys_call = 1;
    sys_call_index = 5'h1f;
    go();
    sys_call = 0;
    chkv(MODE_SYSTEM, 18'h001f8);
  endtask
  task automatic t_user();
    grant_we = 1;
    grant_data = 8'h05;
    go();
    `CHK(user_grants, 8'h05)
    grant_we = 0;
    mode_return = 1;
    return_to_user = 1;
    go();
    mode_return = 0;
    `CHK(mode, MODE_USER)
    grant_we = 1;
    grant_data = 8'hff;
    go();
    grant_we = 0;
    `CHK(user_grants, 8'h05)
    acc(MEM_SFR, 18'h00000, 3'h2, 1'b1);
    cop(1'b0, 17'h00d00, 1'b1);
    acc(MEM_SFR, 18'h00000, 3'h1, 1'b0);
    chkv(MODE_SYSTEM, 18'h000f8);
  endtask
  // An exception outranks a system call taken on the same edge
  task automatic t_exc();
    exc_req = 1;
    exc_index = 5'h03;
    exc_to_user = 1;
    go();
    chkv(MODE_USER, 18'h00018);
    exc_index = 5'h04;
    exc_to_user = 0;
    sys_call = 1;
    sys_call_index = 5'h05;
    go();
    exc_req = 0;
    sys_call = 0;
    chkv(MODE_SYSTEM, 18'h00020);
  endtask
  task automatic t_cop();
    cop(1'b0, 17'h00cff, 1'b0);
    cop(1'b0, 17'h011ff, 1'b1);
    cop(1'b1, 17'h00440, 1'b1);
    cop(1'b1, 17'h0043f, 1'b0);
    cls_ee_cfg = 2'h2;
    acc(MEM_EE, 18'h0103f, 3'h0, 1'b0);
    acc(MEM_EE, 18'h01040, 3'h0, 1'b1);
    cls_ee_cfg = 2'h0;
    ram_rsv_cfg = 0;
    acc(MEM_EE, 18'h0003f, 3'h0, 1'b0);
    acc(MEM_EE, 18'h00040, 3'h0, 1'b1);
    acc(MEM_RAM, 18'h00000, 3'h0, 1'b1);
    acc(MEM_RAM, 18'h01200, 3'h0, 1'b0);
    cop(1'b1, 17'h00040, 1'b1);
  endtask
  // Contactless mode: a refused access stays put, exception and return leave it
  task automatic t_cls();
    cfg_call = 1;
    cfg_call_index = 3'h7;
    go();
    cfg_call = 0;
    chkv(MODE_CLS, 18'h28038);
    acc(MEM_SFR, 18'h00000, 3'h0, 1'b0);
    `CHK(mode, MODE_CLS)
    `CHK(vec_jump, 1'b0)
    exc_req = 1;
    exc_index = 5'h02;
    exc_to_user = 1;
    go();
    exc_req = 0;
    exc_to_user = 0;
    chkv(MODE_USER, 18'h00010);
    cfg_call = 1;
    cfg_call_index = 3'h0;
    go();
    cfg_call = 0;
    chkv(MODE_CLS, 18'h28000);
    mode_return = 1;
    return_to_user = 1;
    go();
    mode_return = 0;
    `CHK(mode, MODE_USER)
  endtask
  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    t_test_path();
    t_startup();
    t_calls();
    t_user();
    t_exc();
    t_cop();
    t_cls();
    summarize();
  end
endmodule
